// [rtl/pin_sync.sv]
// Two-stage synchroniser bank for asynchronous pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 14
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Pins and synchronised copy
  input wire logic [WIDTH-1:0] pins_in,
  output logic [WIDTH-1:0] sync_out
);

  // Both stages held in one packed struct
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t s_q;
  sync_state_t s_d;

  // Shift one stage per edge; first stage feeds only the second
  always_comb
  begin
    s_d = s_q;
    s_d.meta = pins_in;
    s_d.stable = s_q.meta;
  end

  // Synchronous reset clears both stages
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.stable;

endmodule

// [rtl/slave_sm_pkg.sv]
// Shared constants, encodings and state types of the fieldbus slave state machine
package slave_sm_pkg;

  // Register offsets as seen by the network master
  localparam logic [15:0] OFF_STATE_REQUEST = 16'h0120;
  localparam logic [15:0] OFF_STATE_REPORT = 16'h0130;
  localparam logic [15:0] OFF_ERROR_CODE = 16'h0134;
  localparam logic [15:0] OFF_INPUT_BYTE = 16'h4000;
  localparam logic [15:0] OFF_IO_FAULT = 16'h4001;
  localparam logic [15:0] OFF_OUTPUT_BYTE = 16'h5000;

  // Field positions in the request and report registers
  localparam int STATE_LSB = 0;
  localparam int STATE_MSB = 3;
  localparam int ACK_BIT = 4;
  localparam int FLAG_BIT = 4;

  // Reported state encodings (same in request and report)
  localparam logic [3:0] CODE_INIT = 4'h1;
  localparam logic [3:0] CODE_PREOP = 4'h2;
  localparam logic [3:0] CODE_BOOT = 4'h3;
  localparam logic [3:0] CODE_SAFEOP = 4'h4;
  localparam logic [3:0] CODE_OP = 4'h8;

  // Transition error codes
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_BAD_CHANGE = 16'h0011;
  localparam logic [15:0] ERR_UNKNOWN_STATE = 16'h0012;
  localparam logic [15:0] ERR_MBX_BOOT = 16'h0015;
  localparam logic [15:0] ERR_MBX_PREOP = 16'h0016;
  localparam logic [15:0] ERR_SM_CFG = 16'h0017;

  // Fault word bit positions
  localparam int FAULT_OUT_SHORT = 0;
  localparam int FAULT_OUT_SURGE = 1;
  localparam int FAULT_ACT_SHORT = 2;
  localparam int FAULT_ACT_UNDERV = 3;
  localparam int FAULT_SNS_SURGE = 4;
  localparam int FAULT_SNS_UNDERV = 5;
  localparam int FAULT_BITS = 6;

  // Substitute value modes
  localparam logic [1:0] SUBST_ZEROS = 2'h0;
  localparam logic [1:0] SUBST_ONES = 2'h1;
  localparam logic [1:0] SUBST_HOLD = 2'h2;
  localparam logic [1:0] SUBST_PATTERN = 2'h3;

  // Reset values
  localparam logic [4:0] REQUEST_RESET = 5'h01;
  localparam logic [3:0] OUTPUT_RESET = 4'h0;

  // Application states, Gray coded along init, preop, safeop, op
  typedef enum logic [2:0] {
    ST_INIT = 3'h0,
    ST_PREOP = 3'h1,
    ST_SAFEOP = 3'h3,
    ST_OP = 3'h2,
    ST_BOOT = 3'h6
  } app_state_t;

  // Register access request from the fieldbus side
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  // Substitute value configuration
  typedef struct packed {
    logic [1:0] mode;
    logic [3:0] pattern;
  } subst_cfg_t;

  // Whole state of the main module
  typedef struct packed {
    app_state_t state;
    logic flag;
    logic [15:0] err_code;
    logic [4:0] request;
    logic [3:0] out_data;
    logic [3:0] dout;
    logic [31:0] rdata;
    logic rvalid;
  } core_state_t;

endpackage

// [rtl/slave_state_machine.sv]
// Application state machine, status registers and process data of the I/O slave
`timescale 1ns/1ps
module slave_state_machine (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Register access from the fieldbus
  input wire slave_sm_pkg::reg_req_t req_in,
  output logic [31:0] rdata_out,
  output logic rvalid_out,
  // Configuration checks made elsewhere
  input wire logic mbx_cfg_ok_in,
  input wire logic sm_cfg_ok_in,
  input wire slave_sm_pkg::subst_cfg_t subst_in,
  // Field pins
  input wire logic [7:0] din_in,
  input wire logic [slave_sm_pkg::FAULT_BITS-1:0] fault_in,
  output logic [3:0] dout_out,
  // Current state for indicators
  output logic [3:0] state_code_out
);

  // Synchronised pins: faults above, inputs below
  logic [slave_sm_pkg::FAULT_BITS+7:0] pins_sync;
  // Synchronised input byte, bit 7 is input 8
  logic [7:0] din_sync;
  // Synchronised fault bits
  logic [slave_sm_pkg::FAULT_BITS-1:0] fault_sync;

  // Registered state and its next value
  slave_sm_pkg::core_state_t s_q;
  slave_sm_pkg::core_state_t s_d;

  // Decoded request fields of the current write
  logic [3:0] want_code;
  logic want_ack;
  logic req_write;
  logic out_write;

  // Outcome of the transition check
  logic want_known;
  slave_sm_pkg::app_state_t want_state;
  logic refuse;
  logic [15:0] refuse_code;

  // Substitute value for the outputs outside Operational
  logic [3:0] subst_val;
  // Read mux result
  logic [31:0] read_val;

  // Pins come from outside the clock domain, so two flops first
  pin_sync #(
    .WIDTH(slave_sm_pkg::FAULT_BITS + 8)
  ) u_pin_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .pins_in({fault_in, din_in}),
    .sync_out(pins_sync)
  );

  assign din_sync = pins_sync[7:0];
  assign fault_sync = pins_sync[slave_sm_pkg::FAULT_BITS+7:8];

  // Map an internal state onto its reported code
  function automatic logic [3:0] state_code(input slave_sm_pkg::app_state_t st);
    logic [3:0] code;
    code = slave_sm_pkg::CODE_INIT;
    unique case (st)
      slave_sm_pkg::ST_INIT: code = slave_sm_pkg::CODE_INIT;
      slave_sm_pkg::ST_PREOP: code = slave_sm_pkg::CODE_PREOP;
      slave_sm_pkg::ST_SAFEOP: code = slave_sm_pkg::CODE_SAFEOP;
      slave_sm_pkg::ST_OP: code = slave_sm_pkg::CODE_OP;
      slave_sm_pkg::ST_BOOT: code = slave_sm_pkg::CODE_BOOT;
      // Illegal codes report Init
      default: code = slave_sm_pkg::CODE_INIT;
    endcase
    return code;
  endfunction

  // Decode the write strobes
  always_comb
  begin
    req_write = req_in.wr && (req_in.addr == slave_sm_pkg::OFF_STATE_REQUEST);
    out_write = req_in.wr && (req_in.addr == slave_sm_pkg::OFF_OUTPUT_BYTE);
    want_code = req_in.wdata[slave_sm_pkg::STATE_MSB:slave_sm_pkg::STATE_LSB];
    want_ack = req_in.wdata[slave_sm_pkg::ACK_BIT];
  end

  // Translate the requested code into a target state
  always_comb
  begin
    want_known = 1'b1;
    want_state = slave_sm_pkg::ST_INIT;
    unique case (want_code)
      slave_sm_pkg::CODE_INIT: want_state = slave_sm_pkg::ST_INIT;
      slave_sm_pkg::CODE_PREOP: want_state = slave_sm_pkg::ST_PREOP;
      slave_sm_pkg::CODE_BOOT: want_state = slave_sm_pkg::ST_BOOT;
      slave_sm_pkg::CODE_SAFEOP: want_state = slave_sm_pkg::ST_SAFEOP;
      slave_sm_pkg::CODE_OP: want_state = slave_sm_pkg::ST_OP;
      // Any other value is an unknown state
      default: want_known = 1'b0;
    endcase
  end

  // Check whether the requested transition may be made
  always_comb
  begin
    refuse = 1'b0;
    refuse_code = slave_sm_pkg::ERR_NONE;
    if (!want_known)
    begin
      // Unknown target: stay put with its own code
      refuse = 1'b1;
      refuse_code = slave_sm_pkg::ERR_UNKNOWN_STATE;
    end
    else if (want_state != s_q.state && want_state != slave_sm_pkg::ST_INIT)
    begin
      // Going back to Init or staying in the current state is always allowed, so only other targets are checked
      unique case (s_q.state)
        slave_sm_pkg::ST_INIT:
        begin
          if (want_state == slave_sm_pkg::ST_SAFEOP || want_state == slave_sm_pkg::ST_OP)
          begin
            refuse = 1'b1;
            refuse_code = slave_sm_pkg::ERR_BAD_CHANGE;
          end
          else if (!mbx_cfg_ok_in)
          begin
            // mailbox setup checked on leaving Init
            refuse = 1'b1;
            refuse_code = (want_state == slave_sm_pkg::ST_BOOT) ?
              slave_sm_pkg::ERR_MBX_BOOT : slave_sm_pkg::ERR_MBX_PREOP;
          end
        end
        slave_sm_pkg::ST_PREOP:
        begin
          if (want_state == slave_sm_pkg::ST_OP || want_state == slave_sm_pkg::ST_BOOT)
          begin
            // PreOp may only step to SafeOp
            refuse = 1'b1;
            refuse_code = slave_sm_pkg::ERR_BAD_CHANGE;
          end
          else if (!sm_cfg_ok_in)
          begin
            refuse = 1'b1;
            refuse_code = slave_sm_pkg::ERR_SM_CFG;
          end
        end
        slave_sm_pkg::ST_SAFEOP:
        begin
          if (want_state == slave_sm_pkg::ST_BOOT)
          begin
            refuse = 1'b1;
            refuse_code = slave_sm_pkg::ERR_BAD_CHANGE;
          end
          else if (want_state == slave_sm_pkg::ST_OP && !sm_cfg_ok_in)
          begin
            refuse = 1'b1;
            refuse_code = slave_sm_pkg::ERR_SM_CFG;
          end
        end
        slave_sm_pkg::ST_OP:
        begin
          if (want_state == slave_sm_pkg::ST_BOOT)
          begin
            refuse = 1'b1;
            refuse_code = slave_sm_pkg::ERR_BAD_CHANGE;
          end
        end
        slave_sm_pkg::ST_BOOT:
        begin
          // Bootstrap is left only through Init
          refuse = 1'b1;
          refuse_code = slave_sm_pkg::ERR_BAD_CHANGE;
        end
        default:
        begin
          refuse = 1'b1;
          refuse_code = slave_sm_pkg::ERR_BAD_CHANGE;
        end
      endcase
    end
  end

  // Substitute value chosen by the configured mode
  always_comb
  begin
    unique case (subst_in.mode)
      slave_sm_pkg::SUBST_ZEROS: subst_val = 4'h0;
      slave_sm_pkg::SUBST_ONES: subst_val = 4'hf;
      // Holding keeps whatever was last driven
      slave_sm_pkg::SUBST_HOLD: subst_val = s_q.dout;
      slave_sm_pkg::SUBST_PATTERN: subst_val = subst_in.pattern;
    endcase
  end

  // Read multiplexer; unmapped offsets and reserved bits read zero
  always_comb
  begin
    read_val = 32'h0000_0000;
    unique case (req_in.addr)
      slave_sm_pkg::OFF_STATE_REQUEST: read_val = {27'h0, s_q.request};
      slave_sm_pkg::OFF_STATE_REPORT: read_val = {27'h0, s_q.flag, state_code(s_q.state)};
      slave_sm_pkg::OFF_ERROR_CODE: read_val = {16'h0, s_q.err_code};
      slave_sm_pkg::OFF_INPUT_BYTE: read_val = {24'h0, din_sync};
      slave_sm_pkg::OFF_IO_FAULT: read_val = {26'h0, fault_sync};
      slave_sm_pkg::OFF_OUTPUT_BYTE: read_val = {28'h0, s_q.out_data};
      default: read_val = 32'h0000_0000;
    endcase
  end

  // Next-state logic for the whole block
  always_comb
  begin
    s_d = s_q;
    s_d.rvalid = req_in.rd;
    if (req_in.rd)
    begin
      s_d.rdata = read_val;
    end
    // process byte written by the master
    if (out_write)
    begin
      s_d.out_data = req_in.wdata[3:0];
    end
    if (req_write)
    begin
      s_d.request = req_in.wdata[4:0];
      // acknowledge clears, error below may set again
      if (want_ack)
      begin
        s_d.flag = 1'b0;
      end
      if (refuse)
      begin
        // flag and code on refusal, set beats the clear
        s_d.flag = 1'b1;
        s_d.err_code = refuse_code;
      end
      else
      begin
        s_d.state = want_state;
        s_d.err_code = slave_sm_pkg::ERR_NONE;
      end
    end
    // outputs follow process data only in Operational
    if (s_d.state == slave_sm_pkg::ST_OP)
    begin
      s_d.dout = s_d.out_data;
    end
    else
    begin
      s_d.dout = subst_val;
    end
  end

  // State register with synchronous reset
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      // start in Init, clear flag and code
      s_q.state <= slave_sm_pkg::ST_INIT;
      s_q.flag <= 1'b0;
      s_q.err_code <= slave_sm_pkg::ERR_NONE;
      s_q.request <= slave_sm_pkg::REQUEST_RESET;
      s_q.out_data <= slave_sm_pkg::OUTPUT_RESET;
      s_q.dout <= slave_sm_pkg::OUTPUT_RESET;
      s_q.rdata <= 32'h0000_0000;
      s_q.rvalid <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops, except the state code, which is decoded from the state flop
  assign rdata_out = s_q.rdata;
  assign rvalid_out = s_q.rvalid;
  assign dout_out = s_q.dout;
  assign state_code_out = state_code(s_q.state);

endmodule

// [verif/master_model.sv]
// Network master model issuing register writes and reads
`timescale 1ns/1ps
module master_model (
  // Clock
  input wire logic clk_in,
  // Request to the slave and its answer
  output slave_sm_pkg::reg_req_t req_out,
  input wire logic [31:0] rdata_in,
  input wire logic rvalid_in
);
  // Idle bus at time zero
  initial req_out = '0;
  // one-cycle write to any offset, no answer awaited; data passed as given
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_in);
    req_out.wr <= 1'b1;
    req_out.addr <= a;
    req_out.wdata <= d;
    @(posedge clk_in);
    // Released lines show the inverse so stale values never look valid
    req_out.wr <= 1'b0;
    req_out.addr <= ~a;
    req_out.wdata <= ~d;
  endtask
  // Read with a bounded wait for the answer strobe
  task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic ok);
    ok = 1'b0;
    d = '0;
    @(posedge clk_in);
    req_out.rd <= 1'b1;
    req_out.addr <= a;
    @(posedge clk_in);
    req_out.rd <= 1'b0;
    req_out.addr <= ~a;
    for (int i = 0; i < 4 && !ok; i++)
    begin
      @(posedge clk_in);
      if (rvalid_in === 1'b1)
      begin
        ok = 1'b1;
        d = rdata_in;
      end
    end
  endtask
endmodule

// [verif/slave_sm_monitor.sv]
// Concurrent checks on the slave state machine ports
`timescale 1ns/1ps
module slave_sm_monitor (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Register access
  input wire slave_sm_pkg::reg_req_t req_in,
  input wire logic [31:0] rdata_out,
  input wire logic rvalid_out,
  // Configuration and pins
  input wire logic mbx_cfg_ok_in,
  input wire logic sm_cfg_ok_in,
  input wire slave_sm_pkg::subst_cfg_t subst_in,
  input wire logic [7:0] din_in,
  input wire logic [slave_sm_pkg::FAULT_BITS-1:0] fault_in,
  input wire logic [3:0] dout_out,
  input wire logic [3:0] state_code_out
);
  // One clock domain, so one clocking and one reset for all checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // Request register write and its target, decoded once
  wire logic ctl_wr = req_in.wr && (req_in.addr == slave_sm_pkg::OFF_STATE_REQUEST);
  wire logic [3:0] tgt = req_in.wdata[3:0];
  wire logic [3:0] st = state_code_out;
  AST_REPORT_READ: assert property (req_in.rd && !req_in.wr
    && req_in.addr == slave_sm_pkg::OFF_STATE_REPORT
    |=> rdata_out[3:0] == $past(st) && rdata_out[31:5] == 27'h0)
    else $error("report read does not match state");
  AST_READ_ANSWER: assert property (rvalid_out == $past(req_in.rd))
    else $error("read answer strobe mistimed");
  AST_HOLD_STATE: assert property (!ctl_wr |=> $stable(st))
    else $error("state moved without a request");
  AST_GO_PREOP: assert property (ctl_wr && tgt == 4'h2 && st == 4'h1 && mbx_cfg_ok_in
    |=> st == 4'h2) else $error("init to preop not taken");
  AST_REFUSE_JUMP: assert property (ctl_wr && tgt == 4'h8 && st == 4'h1 |=> st == 4'h1)
    else $error("init to op was taken");
  AST_MBX_REFUSE: assert property (ctl_wr && tgt == 4'h2 && st == 4'h1 && !mbx_cfg_ok_in
    |=> st == 4'h1) else $error("preop taken with bad mailbox");
  AST_SM_REFUSE: assert property (ctl_wr && tgt == 4'h4 && st == 4'h2 && !sm_cfg_ok_in
    |=> st == 4'h2) else $error("safeop taken with bad sync config");
  AST_OUT_DRIVE: assert property (req_in.wr && req_in.addr == slave_sm_pkg::OFF_OUTPUT_BYTE
    && st == 4'h8 |=> dout_out == $past(req_in.wdata[3:0])) else $error("outputs not driven");
  AST_SUBST_ZERO: assert property ((st != 4'h8 && subst_in.mode == slave_sm_pkg::SUBST_ZEROS)[*2]
    |-> dout_out == 4'h0) else $error("outputs not at substitute zeros");
  // input byte read; two sync stages, so inputs held steady first
  AST_INPUT_BYTE: assert property ($stable(din_in)[*3] ##0 (req_in.rd
    && req_in.addr == slave_sm_pkg::OFF_INPUT_BYTE) |=> rdata_out == {24'h0, $past(din_in)})
    else $error("input byte read wrong");
endmodule

// [verif/tb_top.sv]
// Self-checking bench for the slave state machine
`timescale 1ns/1ps
module tb_top;
  // One table row: request, config ok, expected state and code
  typedef struct packed {
    logic [7:0] req;
    logic ok;
    logic [3:0] st;
    logic [15:0] code;
  } row_t;
  // Design signals
  logic clk_in;
  logic resetn_in;
  slave_sm_pkg::reg_req_t req_in;
  slave_sm_pkg::subst_cfg_t subst_in;
  logic mbx_cfg_ok_in;
  logic sm_cfg_ok_in;
  logic [7:0] din_in;
  logic [5:0] fault_in;
  logic [31:0] rdata_out;
  logic rvalid_out;
  logic [3:0] dout_out;
  logic [3:0] state_code_out;
  // Bench bookkeeping
  int errors;
  int checks;
  logic flag;
  logic ok;
  logic [31:0] rd_v;
  row_t rows [18];
  // Design under test and the master facing it
  slave_state_machine dut_u (.clk_in(clk_in), .resetn_in(resetn_in), .req_in(req_in),
    .rdata_out(rdata_out), .rvalid_out(rvalid_out), .mbx_cfg_ok_in(mbx_cfg_ok_in),
    .sm_cfg_ok_in(sm_cfg_ok_in), .subst_in(subst_in), .din_in(din_in), .fault_in(fault_in),
    .dout_out(dout_out), .state_code_out(state_code_out));
  master_model master_u (.clk_in(clk_in), .req_out(req_in), .rdata_in(rdata_out),
    .rvalid_in(rvalid_out));
  // 100 MHz clock
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Register read and compare; a lost answer ends the run
  task automatic rdc(input logic [15:0] a, input logic [31:0] exp);
    master_u.rd(a, rd_v, ok);
    if (ok !== 1'b1)
    begin
      errors++;
      $display("ERROR %0t: read answer missing", $time);
      wrap_up();
    end
    else
      chk(rd_v, exp);
  endtask
  // Main sequence
  initial
  begin
    resetn_in = 1'b0;
    subst_in = '0;
    mbx_cfg_ok_in = 1'b1;
    sm_cfg_ok_in = 1'b1;
    din_in = 8'h00;
    fault_in = 6'h00;
    errors = 0;
    checks = 0;
    flag = 1'b0;
    rows = '{'{8'h08, 1'b1, 4'h1, 16'h0011}, '{8'h04, 1'b1, 4'h1, 16'h0011},
      '{8'h03, 1'b0, 4'h1, 16'h0015}, '{8'h02, 1'b0, 4'h1, 16'h0016},
      '{8'h05, 1'b1, 4'h1, 16'h0012}, '{8'h13, 1'b1, 4'h3, 16'h0000},
      '{8'h12, 1'b1, 4'h3, 16'h0011}, '{8'h01, 1'b1, 4'h1, 16'h0000},
      '{8'h12, 1'b1, 4'h2, 16'h0000}, '{8'h08, 1'b1, 4'h2, 16'h0011},
      '{8'h03, 1'b1, 4'h2, 16'h0011}, '{8'h04, 1'b0, 4'h2, 16'h0017},
      '{8'h14, 1'b1, 4'h4, 16'h0000}, '{8'h03, 1'b1, 4'h4, 16'h0011},
      '{8'h08, 1'b0, 4'h4, 16'h0017}, '{8'h18, 1'b1, 4'h8, 16'h0000},
      '{8'h03, 1'b1, 4'h8, 16'h0011}, '{8'h11, 1'b1, 4'h1, 16'h0000}};
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'b1;
    rdc(slave_sm_pkg::OFF_STATE_REPORT, 32'h1);
    rdc(slave_sm_pkg::OFF_ERROR_CODE, 32'h0);
    rdc(slave_sm_pkg::OFF_STATE_REQUEST, 32'h1);
    $display("Test reset done");
    foreach (rows[i])
    begin
      mbx_cfg_ok_in <= rows[i].ok;
      sm_cfg_ok_in <= rows[i].ok;
      master_u.wr(slave_sm_pkg::OFF_STATE_REQUEST, {24'h0, rows[i].req});
      // An error sets the flag, ack alone clears it, set wins
      flag = (rows[i].code !== 16'h0) | (flag & !rows[i].req[4]);
      rdc(slave_sm_pkg::OFF_STATE_REPORT, {27'h0, flag, rows[i].st});
      rdc(slave_sm_pkg::OFF_ERROR_CODE, {16'h0, rows[i].code});
      chk({28'h0, state_code_out}, {28'h0, rows[i].st});
    end
    $display("Test table done");
    // outputs in and out of Operational
    subst_in <= '{slave_sm_pkg::SUBST_HOLD, 4'h9};
    master_u.wr(slave_sm_pkg::OFF_STATE_REQUEST, 32'h12);
    master_u.wr(slave_sm_pkg::OFF_STATE_REQUEST, 32'h14);
    master_u.wr(slave_sm_pkg::OFF_STATE_REQUEST, 32'h18);
    master_u.wr(slave_sm_pkg::OFF_OUTPUT_BYTE, 32'ha5);
    #1;
    chk({28'h0, dout_out}, 32'h5);
    rdc(slave_sm_pkg::OFF_OUTPUT_BYTE, 32'h5);
    master_u.wr(slave_sm_pkg::OFF_STATE_REQUEST, 32'h04);
    #1;
    chk({28'h0, dout_out}, 32'h5);
    for (int m = 0; m < 4; m++)
    begin
      @(posedge clk_in);
      subst_in <= '{2'(m), 4'h9};
      repeat (2) @(posedge clk_in);
      #1;
      chk({28'h0, dout_out}, (m == 0) ? 32'h0 : (m == 3) ? 32'h9 : 32'hf);
    end
    $display("Test outputs done");
    for (int b = 0; b < 8; b++)
    begin
      @(posedge clk_in);
      din_in <= 8'h1 << b;
      fault_in <= 6'(32'h1 << b);
      repeat (4) @(posedge clk_in);
      rdc(slave_sm_pkg::OFF_INPUT_BYTE, 32'h1 << b);
      rdc(slave_sm_pkg::OFF_IO_FAULT, (32'h1 << b) & 32'h3f);
    end
    $display("Test pins done");
    // read-only writes, unmapped read, second reset
    master_u.wr(slave_sm_pkg::OFF_STATE_REPORT, 32'h18);
    rdc(slave_sm_pkg::OFF_STATE_REPORT, 32'h4);
    master_u.wr(slave_sm_pkg::OFF_ERROR_CODE, 32'h1234);
    rdc(slave_sm_pkg::OFF_ERROR_CODE, 32'h0);
    rdc(16'h0200, 32'h0);
    // Leave a refusal pending so the reset has flag and code to clear
    master_u.wr(slave_sm_pkg::OFF_STATE_REQUEST, 32'h03);
    rdc(slave_sm_pkg::OFF_ERROR_CODE, 32'h11);
    @(posedge clk_in);
    resetn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    #1;
    chk({28'h0, dout_out}, 32'h0);
    rdc(slave_sm_pkg::OFF_STATE_REPORT, 32'h1);
    rdc(slave_sm_pkg::OFF_ERROR_CODE, 32'h0);
    chk({28'h0, dout_out}, 32'h9);
    $display("Test refusals done");
    wrap_up();
  end
endmodule
// Checker beside the design's ports
bind slave_state_machine slave_sm_monitor mon_u (.clk_in(clk_in), .resetn_in(resetn_in),
  .req_in(req_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out),
  .mbx_cfg_ok_in(mbx_cfg_ok_in), .sm_cfg_ok_in(sm_cfg_ok_in), .subst_in(subst_in),
  .din_in(din_in), .fault_in(fault_in), .dout_out(dout_out), .state_code_out(state_code_out));
